// ===== src/psfs_top.sv
// Purpose: apb-reached pin-shared function selection for ports a, b, c
// Assumes: peripherals sit outside; pins are 3-signal pads
// Notes:   pin state is synchronised before any logic reads it
`timescale 1ns/1ps
`include "psfs_map.svh"
module psfs_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  pa_in,
  output logic      [7:0]  pa_out,
  output logic      [7:0]  pa_oe,
  input  wire logic [3:0]  pb_in,
  output logic      [3:0]  pb_out,
  output logic      [3:0]  pb_oe,
  input  wire logic [5:0]  pc_in,
  output logic      [5:0]  pc_out,
  output logic      [5:0]  pc_oe,
  input  wire logic        timer0_output,
  input  wire logic        timer1_output,
  input  wire logic        timer2_output,
  input  wire logic        timer3_output,
  input  wire logic        opamp_output,
  input  wire logic        hall_a_output,
  input  wire logic        hall_b_output,
  input  wire logic        hall_c_output,
  input  wire logic        gate_a_top,
  input  wire logic        gate_a_bottom,
  input  wire logic        gate_b_top,
  input  wire logic        gate_b_bottom,
  input  wire logic        gate_c_top,
  input  wire logic        gate_c_bottom,
  input  wire logic        power_down,
  output logic [7:0]       analog_enable,
  output logic             external_interrupt_input,
  output logic             capture_timer_input,
  output logic             noise_filter_input,
  output logic             wake_request
);
  logic [7:0]  input_source_routing_reg, port_a_wake_enable_reg;
  logic [7:0]  port_a_low_select_reg, port_a_high_select_reg;
  logic [7:0]  port_b_select_reg, port_c_low_select_reg;
  logic [7:0]  port_c_high_select_reg, pa_prev_reg, analog_reg;
  logic [7:0]  pa_dat_reg, pb_dat_reg, pc_dat_reg;
  logic [7:0]  pa_dir_reg, pb_dir_reg, pc_dir_reg;
  logic        wake_reg, irq_reg, cap_reg, nf_reg;
  logic [17:0] pin_in_all, latch_all, dir_all, psel_all, pout_all;
  logic [17:0] asel_all, out_all, oe_all, sync_all, rd_all;
  logic [7:0]  pa_sync, pa_gpio, wbyte, bitop_sel_port, rmw_next;
  logic        wr_en, rd_en, hit;
  logic [31:0] rdata_next;
  logic [1:0]  pa0_c, pa1_c, pa2_c, pa3_c, pa4_c, pa5_c, pa6_c, pa7_c;
  logic [1:0]  pb0_c, pb1_c, pb2_c, pb3_c;
  logic [1:0]  pc_c [0:5];

  // zero wait-state apb: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign wbyte   = pwdata[7:0];

  // bit op word: [9:8] port (0 a,1 b,2 c), [3] dir vs data,
  // [2:0] bit, [7] value; the port is read, one bit changed, written back
  always_comb
  begin
    bitop_sel_port = 8'h00;
    case (pwdata[9:8])
      2'h0: bitop_sel_port = pwdata[3] ? pa_dir_reg : rd_all[7:0];
      2'h1: bitop_sel_port = pwdata[3] ? pb_dir_reg : {4'h0, rd_all[11:8]};
      2'h2: bitop_sel_port = pwdata[3] ? pc_dir_reg : {2'h0, rd_all[17:12]};
      default: bitop_sel_port = 8'h00;
    endcase
    // input bits pick up the pad level, as a port read-modify-write does
    rmw_next = bitop_sel_port;
    rmw_next[pwdata[2:0]] = pwdata[7];
  end

  function automatic logic bitop_hit(input logic [1:0] port,
                                     input logic       is_dir);
    bitop_hit = wr_en && (paddr == `PSFS_OFF_BITOP)
                && (pwdata[9:8] == port) && (pwdata[3] == is_dir);
  endfunction : bitop_hit

  // selection and routing registers take effect at the write edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      input_source_routing_reg <= `PSFS_SEL_RST;
      port_a_low_select_reg    <= `PSFS_SEL_RST;
      port_a_high_select_reg   <= `PSFS_SEL_RST;
      port_b_select_reg        <= `PSFS_SEL_RST;
      port_c_low_select_reg    <= `PSFS_SEL_RST;
      port_c_high_select_reg   <= `PSFS_SEL_RST;
      port_a_wake_enable_reg   <= `PSFS_SEL_RST;
    end
    else if (wr_en)
    begin
      case (paddr)
        `PSFS_OFF_ROUTE:
          input_source_routing_reg <= wbyte & `PSFS_ROUTE_MASK;
        `PSFS_OFF_PA_LO: port_a_low_select_reg  <= wbyte;
        `PSFS_OFF_PA_HI: port_a_high_select_reg <= wbyte;
        `PSFS_OFF_PB:    port_b_select_reg      <= wbyte;
        `PSFS_OFF_PC_LO: port_c_low_select_reg  <= wbyte;
        `PSFS_OFF_PC_HI:
          port_c_high_select_reg <= wbyte & `PSFS_PCHI_MASK;
        `PSFS_OFF_WAKE:  port_a_wake_enable_reg <= wbyte;
        default: ;
      endcase
    end
  end

  // port latches and directions start high: all pins inputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pa_dat_reg <= `PSFS_PORT_RST;
      pb_dat_reg <= `PSFS_PORT_RST;
      pc_dat_reg <= `PSFS_PORT_RST;
      pa_dir_reg <= `PSFS_PORT_RST;
      pb_dir_reg <= `PSFS_PORT_RST;
      pc_dir_reg <= `PSFS_PORT_RST;
    end
    else
    begin
      if (wr_en && paddr == `PSFS_OFF_PA_DAT) pa_dat_reg <= wbyte;
      if (wr_en && paddr == `PSFS_OFF_PB_DAT) pb_dat_reg <= wbyte;
      if (wr_en && paddr == `PSFS_OFF_PC_DAT) pc_dat_reg <= wbyte;
      if (wr_en && paddr == `PSFS_OFF_PA_DIR) pa_dir_reg <= wbyte;
      if (wr_en && paddr == `PSFS_OFF_PB_DIR) pb_dir_reg <= wbyte;
      if (wr_en && paddr == `PSFS_OFF_PC_DIR) pc_dir_reg <= wbyte;
      if (bitop_hit(2'h0, 1'b0)) pa_dat_reg <= rmw_next;
      if (bitop_hit(2'h1, 1'b0)) pb_dat_reg <= rmw_next;
      if (bitop_hit(2'h2, 1'b0)) pc_dat_reg <= rmw_next;
      if (bitop_hit(2'h0, 1'b1)) pa_dir_reg <= rmw_next;
      if (bitop_hit(2'h1, 1'b1)) pb_dir_reg <= rmw_next;
      if (bitop_hit(2'h2, 1'b1)) pc_dir_reg <= rmw_next;
    end
  end

  assign pa3_c = port_a_low_select_reg[7:6];
  assign pa2_c = port_a_low_select_reg[5:4];
  assign pa1_c = port_a_low_select_reg[3:2];
  assign pa0_c = port_a_low_select_reg[1:0];
  assign pa7_c = port_a_high_select_reg[7:6];
  assign pa6_c = port_a_high_select_reg[5:4];
  assign pa5_c = port_a_high_select_reg[3:2];
  assign pa4_c = port_a_high_select_reg[1:0];
  assign pb3_c = port_b_select_reg[7:6];
  assign pb2_c = port_b_select_reg[5:4];
  assign pb1_c = port_b_select_reg[3:2];
  assign pb0_c = port_b_select_reg[1:0];
  assign pc_c[0] = port_c_low_select_reg[1:0];
  assign pc_c[1] = port_c_low_select_reg[3:2];
  assign pc_c[2] = port_c_low_select_reg[5:4];
  assign pc_c[3] = port_c_low_select_reg[7:6];
  assign pc_c[4] = port_c_high_select_reg[1:0];
  assign pc_c[5] = port_c_high_select_reg[3:2];

  // per-pin mux: index 0-7 port a, 8-11 port b, 12-17 port c
  always_comb
  begin
    psel_all = '0;
    pout_all = '0;
    asel_all = '0;
    // pa0 and pa2 stay gpio on every code
    psel_all[0] = 1'b0;
    psel_all[2] = 1'b0;
    psel_all[1] = (pa1_c == psfs_pkg::PSFS_CODE2);
    pout_all[1] = timer2_output;
    asel_all[1] = (pa1_c == psfs_pkg::PSFS_CODE1);
    psel_all[3] = (pa3_c == psfs_pkg::PSFS_CODE1);
    pout_all[3] = timer1_output;
    psel_all[4] = (pa4_c == psfs_pkg::PSFS_CODE2);
    pout_all[4] = timer2_output;
    psel_all[5] = (pa5_c == psfs_pkg::PSFS_CODE2);
    pout_all[5] = timer3_output;
    asel_all[6] = (pa6_c == psfs_pkg::PSFS_CODE1);
    asel_all[7] = (pa7_c == psfs_pkg::PSFS_CODE1);
    psel_all[7] = (pa7_c == psfs_pkg::PSFS_CODE2);
    pout_all[7] = opamp_output;
    psel_all[8]  = (pb0_c == psfs_pkg::PSFS_CODE3);
    pout_all[8]  = hall_a_output;
    asel_all[8]  = (pb0_c == psfs_pkg::PSFS_CODE2);
    psel_all[9]  = pb1_c[0];
    pout_all[9]  = pb1_c[1] ? hall_b_output : timer1_output;
    asel_all[9]  = (pb1_c == psfs_pkg::PSFS_CODE2);
    psel_all[10] = pb2_c[0];
    pout_all[10] = pb2_c[1] ? hall_c_output : timer1_output;
    asel_all[10] = (pb2_c == psfs_pkg::PSFS_CODE2);
    psel_all[11] = (pb3_c == psfs_pkg::PSFS_CODE1);
    pout_all[11] = timer0_output;
    // port c: code 01 timer, code 10 gate drive
    psel_all[12] = (pc_c[0] == 2'h1) || (pc_c[0] == 2'h2);
    pout_all[12] = pc_c[0][1] ? gate_a_top : timer0_output;
    psel_all[13] = (pc_c[1] == 2'h1) || (pc_c[1] == 2'h2);
    pout_all[13] = pc_c[1][1] ? gate_a_bottom : timer0_output;
    psel_all[14] = (pc_c[2] == 2'h1) || (pc_c[2] == 2'h2);
    pout_all[14] = pc_c[2][1] ? gate_b_top : timer2_output;
    psel_all[15] = (pc_c[3] == 2'h1) || (pc_c[3] == 2'h2);
    pout_all[15] = pc_c[3][1] ? gate_b_bottom : timer2_output;
    psel_all[16] = (pc_c[4] == 2'h1) || (pc_c[4] == 2'h2);
    pout_all[16] = pc_c[4][1] ? gate_c_top : timer3_output;
    psel_all[17] = (pc_c[5] == 2'h1) || (pc_c[5] == 2'h2);
    pout_all[17] = pc_c[5][1] ? gate_c_bottom : timer3_output;
  end

  assign pin_in_all = {pc_in, pb_in, pa_in};
  assign latch_all  = {pc_dat_reg[5:0], pb_dat_reg[3:0], pa_dat_reg};
  assign dir_all    = {pc_dir_reg[5:0], pb_dir_reg[3:0], pa_dir_reg};

  genvar gi;
  generate
    for (gi = 0; gi < 18; gi++)
    begin : g_pin
      psfs_pin_cell u_cell (
        .pclk       (pclk),
        .presetn    (presetn),
        .pin_in     (pin_in_all[gi]),
        .latch_bit  (latch_all[gi]),
        .dir_bit    (dir_all[gi]),
        .periph_sel (psel_all[gi]),
        .periph_out (pout_all[gi]),
        .analog_sel (asel_all[gi]),
        .pin_out    (out_all[gi]),
        .pin_oe     (oe_all[gi]),
        .pin_sync   (sync_all[gi]),
        .read_bit   (rd_all[gi])
      );
    end
  endgenerate

  assign pa_out = out_all[7:0];
  assign pa_oe  = oe_all[7:0];
  assign pb_out = out_all[11:8];
  assign pb_oe  = oe_all[11:8];
  assign pc_out = out_all[17:12];
  assign pc_oe  = oe_all[17:12];
  assign pa_sync = sync_all[7:0];

  // input routing, registered so the peripheral sees a clean level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_reg    <= 1'b1;
      cap_reg    <= 1'b1;
      nf_reg     <= 1'b1;
      analog_reg <= 8'h00;
    end
    else
    begin
      case (input_source_routing_reg[`PSFS_IRQ_LSB +: 2])
        2'h1:    irq_reg <= sync_all[11];
        2'h2:    irq_reg <= sync_all[8];
        default: irq_reg <= sync_all[7];
      endcase
      cap_reg <= input_source_routing_reg[`PSFS_CAP_BIT] ?
                 sync_all[6] : sync_all[9];
      case (input_source_routing_reg[`PSFS_NF_LSB +: 2])
        2'h1:    nf_reg <= sync_all[6];
        2'h2:    nf_reg <= sync_all[8];
        default: nf_reg <= sync_all[7];
      endcase
      // analog channels 0,1,2,3,6,7; 4,5 unused here
      analog_reg <= {asel_all[6], asel_all[7], 2'b00, asel_all[1],
                     asel_all[8], asel_all[9], asel_all[10]};
    end
  end

  assign external_interrupt_input = irq_reg;
  assign capture_timer_input      = cap_reg;
  assign noise_filter_input       = nf_reg;
  assign analog_enable            = analog_reg;

  // a pin counts as gpio only when no peripheral or analog owns it
  assign pa_gpio = ~(psel_all[7:0] | asel_all[7:0]);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pa_prev_reg <= `PSFS_PORT_RST;
      wake_reg    <= 1'b0;
    end
    else
    begin
      pa_prev_reg <= pa_sync;
      wake_reg    <= power_down &&
                     |(pa_prev_reg & ~pa_sync & port_a_wake_enable_reg
                       & pa_gpio);
    end
  end

  assign wake_request = wake_reg;

  always_comb
  begin
    hit = 1'b1;
    rdata_next = 32'h0000_0000;
    case (paddr)
      `PSFS_OFF_ROUTE:  rdata_next[7:0] = input_source_routing_reg;
      `PSFS_OFF_PA_LO:  rdata_next[7:0] = port_a_low_select_reg;
      `PSFS_OFF_PA_HI:  rdata_next[7:0] = port_a_high_select_reg;
      `PSFS_OFF_PB:     rdata_next[7:0] = port_b_select_reg;
      `PSFS_OFF_PC_LO:  rdata_next[7:0] = port_c_low_select_reg;
      `PSFS_OFF_PC_HI:  rdata_next[7:0] = port_c_high_select_reg;
      `PSFS_OFF_PA_DAT: rdata_next[7:0] = rd_all[7:0];
      `PSFS_OFF_PB_DAT: rdata_next[7:0] = {4'h0, rd_all[11:8]};
      `PSFS_OFF_PC_DAT: rdata_next[7:0] = {2'h0, rd_all[17:12]};
      `PSFS_OFF_PA_DIR: rdata_next[7:0] = pa_dir_reg;
      `PSFS_OFF_PB_DIR: rdata_next[7:0] = pb_dir_reg & `PSFS_PB_MASK;
      `PSFS_OFF_PC_DIR: rdata_next[7:0] = pc_dir_reg & `PSFS_PC_MASK;
      `PSFS_OFF_WAKE:   rdata_next[7:0] = port_a_wake_enable_reg;
      default:          hit = 1'b0;
    endcase
  end

  // unmapped addresses read zero; no error is signalled
  assign prdata = (rd_en && hit) ? rdata_next : 32'h0000_0000;

  chk_route_irq_pb0: assert property (@(posedge pclk)
    disable iff (!presetn) input_source_routing_reg[6:5] == 2'h2 |=>
    irq_reg == $past(sync_all[8])) else $error("irq source not pb0");
  chk_cap_route: assert property (@(posedge pclk)
    disable iff (!presetn) !input_source_routing_reg[4] |=>
    cap_reg == $past(sync_all[9])) else $error("capture source not pb1");
  chk_nf_route_pa6: assert property (@(posedge pclk)
    disable iff (!presetn) input_source_routing_reg[3:2] == 2'h1 |=>
    nf_reg == $past(sync_all[6])) else $error("noise filter not pa6");
  chk_unimpl_zero: assert property (@(posedge pclk)
    disable iff (!presetn) input_source_routing_reg[7] == 1'b0 &&
    input_source_routing_reg[1:0] == 2'h0 && port_c_high_select_reg[7:4]
    == 4'h0) else $error("unimplemented bit set");
  chk_pa3_timer: assert property (@(posedge pclk)
    disable iff (!presetn) pa3_c == 2'h1 |->
    pa_out[3] == timer1_output && pa_oe[3]) else $error("pa3 not timer1");
  chk_pa_gpio_keep: assert property (@(posedge pclk)
    disable iff (!presetn) pa_out[0] == pa_dat_reg[0] &&
    pa_out[2] == pa_dat_reg[2]) else $error("pa0 or pa2 left gpio");
  chk_pc0_gate: assert property (@(posedge pclk)
    disable iff (!presetn) pc_c[0] == 2'h2 |->
    pc_out[0] == gate_a_top && pc_oe[0]) else $error("pc0 not gate a top");
  chk_pb2_hall: assert property (@(posedge pclk)
    disable iff (!presetn) pb2_c == 2'h3 |->
    pb_out[2] == hall_c_output) else $error("pb2 not hall c");
  chk_sel_update: assert property (@(posedge pclk)
    disable iff (!presetn) wr_en && paddr == `PSFS_OFF_PA_LO |=>
    port_a_low_select_reg == $past(wbyte)) else $error("select write lost");
  chk_wake_gate: assert property (@(posedge pclk)
    disable iff (!presetn) !$past(power_down) |->
    !wake_request) else $error("wake outside power-down");
endmodule : psfs_top

// ===== src/psfs_map.svh
// Purpose: register offsets, field positions and reset values for the
//          pin-shared function select block
// Assumes: apb byte addresses, one 32-bit word per register
// Notes:   none
// How it works
// - irq source field picks pa7, pb3 or pb0
// - capture source bit picks pb1 or pa6
// - noise filter field picks pa7, pa6, pb0
// - unimplemented routing and select bits read zero
// - pa3 code 01 drives timer1 output
// - pa2 and pa0 always stay gpio
// - pa1 analog3 on 01, timer2 on 10
// - pa7 analog6 on 01, opamp on 10
// - pa6 analog7 on 01, else gpio
// - pa5 timer3, pa4 timer2 on code 10
// - pb3 code 01 drives timer0 output
// - pb2 timer1, analog0, hall c by code
// - pb1 timer1, analog1, hall b by code
// - pb0 analog2 on 10, hall a 11
// - pc0-3 timer, gate drives by code
// - pc4-5 timer3 or gate c drives
// - data latches and directions reset high
// - bit set or clear is read-modify-write
// - port a falling edge wakes in power-down
// - direction 1 input; output reads latch
// - wake works only as gpio in power-down
`ifndef PSFS_MAP_SVH
`define PSFS_MAP_SVH
`define PSFS_OFF_ROUTE   12'h000
`define PSFS_OFF_PA_LO   12'h004
`define PSFS_OFF_PA_HI   12'h008
`define PSFS_OFF_PB      12'h00C
`define PSFS_OFF_PC_LO   12'h010
`define PSFS_OFF_PC_HI   12'h014
`define PSFS_OFF_PA_DAT  12'h018
`define PSFS_OFF_PB_DAT  12'h01C
`define PSFS_OFF_PC_DAT  12'h020
`define PSFS_OFF_PA_DIR  12'h024
`define PSFS_OFF_PB_DIR  12'h028
`define PSFS_OFF_PC_DIR  12'h02C
`define PSFS_OFF_WAKE    12'h030
`define PSFS_OFF_BITOP   12'h034
`define PSFS_ROUTE_MASK  8'h7C
`define PSFS_PCHI_MASK   8'h0F
`define PSFS_PB_MASK     8'h0F
`define PSFS_PC_MASK     8'h3F
`define PSFS_SEL_RST     8'h00
`define PSFS_PORT_RST    8'hFF
`define PSFS_IRQ_LSB     5
`define PSFS_CAP_BIT     4
`define PSFS_NF_LSB      2
`endif

// ===== src/psfs_pkg.sv
// Purpose: shared types for the pin-shared function select block
// Assumes: none
// Notes:   codes of a two-bit pin selection field
package psfs_pkg;
  typedef enum logic [1:0] {
    PSFS_CODE0 = 2'h0,
    PSFS_CODE1 = 2'h1,
    PSFS_CODE2 = 2'h2,
    PSFS_CODE3 = 2'h3
  } psfs_code_type;
endpackage : psfs_pkg

// ===== src/psfs_pin_cell.sv
// Purpose: one port pin: gpio or peripheral output, and input sync
// Assumes: pin input arrives asynchronously
// Notes:   peripheral overrides the gpio driver while selected
`timescale 1ns/1ps
module psfs_pin_cell (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin_in,
  input  wire logic latch_bit,
  input  wire logic dir_bit,
  input  wire logic periph_sel,
  input  wire logic periph_out,
  input  wire logic analog_sel,
  output logic      pin_out,
  output logic      pin_oe,
  output logic      pin_sync,
  output logic      read_bit
);
  logic meta_reg;
  logic sync_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
    end
    else
    begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
    end
  end

  // analog keeps the digital driver off so the pad stays high impedance
  always_comb
  begin
    pin_out = periph_sel ? periph_out : latch_bit;
    pin_oe  = !analog_sel && (periph_sel || !dir_bit);
  end

  assign pin_sync = sync_reg;
  assign read_bit = dir_bit ? sync_reg : latch_bit;
endmodule : psfs_pin_cell

// ===== verification/testbench.sv
// Purpose: self-checking bench for psfs_top against a table model
// Assumes: apb slave answers in the access cycle, pins synced in 2 flops
// Notes:   peripheral levels and pads are random; seed fixed
`timescale 1ns/1ps
`include "psfs_map.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr, a;
  logic [31:0] pwdata, prdata, d;
  logic [7:0]  pa_in, pa_out, pa_oe, analog_enable, route, wake;
  logic [3:0]  pb_in, pb_out, pb_oe;
  logic [5:0]  pc_in, pc_out, pc_oe;
  logic [13:0] per;
  logic        power_down, wake_request, got, ex;
  logic        external_interrupt_input, capture_timer_input;
  logic        noise_filter_input;
  logic [7:0]  sel [5];
  logic [7:0]  dat [3];
  logic [7:0]  dir [3];
  int          errors, cmp_count, cyc, p;
  // [19:16] analog channel, then a nibble per code 3..0:
  // 0 gpio, f analog, else peripheral index plus one
  localparam logic [19:0] tbl [18] = '{20'h0_0000, 20'h3_03F0,
    20'h0_0000, 20'h0_0020, 20'h0_0300, 20'h0_0400, 20'h7_00F0,
    20'h6_05F0, 20'h2_6F00, 20'h1_7F20, 20'h0_8F20, 20'h0_0010,
    20'h0_0910, 20'h0_0A10, 20'h0_0B30, 20'h0_0C30, 20'h0_0D40,
    20'h0_0E40};

  psfs_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .pa_in, .pa_out, .pa_oe, .pb_in,
    .pb_out, .pb_oe, .pc_in, .pc_out, .pc_oe, .timer0_output(per[0]),
    .timer1_output(per[1]), .timer2_output(per[2]), .timer3_output(per[3]),
    .opamp_output(per[4]), .hall_a_output(per[5]), .hall_b_output(per[6]),
    .hall_c_output(per[7]), .gate_a_top(per[8]), .gate_a_bottom(per[9]),
    .gate_b_top(per[10]), .gate_b_bottom(per[11]), .gate_c_top(per[12]),
    .gate_c_bottom(per[13]), .power_down, .analog_enable,
    .external_interrupt_input, .capture_timer_input, .noise_filter_input,
    .wake_request);

  function automatic int port_of(int q);
    return (q < 8) ? 0 : (q < 12) ? 1 : 2;
  endfunction : port_of

  function automatic int bit_of(int q);
    return (q < 8) ? q : (q < 12) ? q - 8 : q - 12;
  endfunction : bit_of

  function automatic logic [7:0] msk(int k);
    return (k == 0) ? 8'hFF : (k == 1) ? 8'h0F : 8'h3F;
  endfunction : msk

  function automatic logic [3:0] kind_of(int q);
    int b;
    int r;
    b = bit_of(q);
    r = (q < 8) ? b / 4 : (q < 12) ? 2 : 3 + b / 4;
    return tbl[q][4 * sel[r][2 * (b % 4) +: 2] +: 4];
  endfunction : kind_of

  // a read of a port returns the pad for inputs, the latch for outputs
  function automatic logic [7:0] rd_port(int k);
    logic [7:0] pin;
    pin = (k == 0) ? pa_in : (k == 1) ? {4'h0, pb_in} : {2'h0, pc_in};
    return ((dir[k] & pin) | (~dir[k] & dat[k])) & msk(k);
  endfunction : rd_port

  function automatic logic [7:0] exp_rd(logic [11:0] x);
    if (x == `PSFS_OFF_ROUTE) return route;
    if (x <= `PSFS_OFF_PC_HI) return sel[x / 4 - 1];
    if (x <= `PSFS_OFF_PC_DAT) return rd_port((x - `PSFS_OFF_PA_DAT) / 4);
    if (x <= `PSFS_OFF_PC_DIR)
      return dir[(x - `PSFS_OFF_PA_DIR) / 4] & msk((x - 12'h024) / 4);
    if (x == `PSFS_OFF_WAKE) return wake;
    return 8'h00;
  endfunction : exp_rd

  task automatic wr_model(logic [11:0] x, logic [31:0] v);
    int k;
    logic [7:0] t;
    k = v[9:8];
    if (x == `PSFS_OFF_ROUTE) route = v[7:0] & `PSFS_ROUTE_MASK;
    else if (x == `PSFS_OFF_PC_HI) sel[4] = v[7:0] & `PSFS_PCHI_MASK;
    else if (x <= `PSFS_OFF_PC_LO) sel[x / 4 - 1] = v[7:0];
    else if (x <= `PSFS_OFF_PC_DAT) dat[(x - 12'h018) / 4] = v[7:0];
    else if (x <= `PSFS_OFF_PC_DIR) dir[(x - 12'h024) / 4] = v[7:0];
    else if (x == `PSFS_OFF_WAKE) wake = v[7:0];
    else if (x == `PSFS_OFF_BITOP && k < 3)
    begin
      t = v[3] ? dir[k] : rd_port(k);
      t[v[2:0]] = v[7];
      if (v[3]) dir[k] = t;
      else dat[k] = t;
    end
  endtask : wr_model

  task automatic apb(logic w, logic [11:0] x, logic [31:0] v);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= x;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    if (w) wr_model(x, v);
    else `CHK({pslverr, prdata}, {25'h0, exp_rd(x)})
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk_pins();
    logic [17:0] oe;
    logic [17:0] out;
    logic [17:0] pins;
    logic [7:0]  an;
    logic [3:0]  kd;
    pins = {pc_in, pb_in, pa_in};
    an = 8'h00;
    for (int q = 0; q < 18; q++)
    begin
      kd = kind_of(q);
      oe[q] = (kd == 4'h0) ? ~dir[port_of(q)][bit_of(q)] : (kd != 4'hF);
      out[q] = (kd == 4'h0) ? dat[port_of(q)][bit_of(q)] : per[kd - 1];
      if (kd == 4'hF) an[tbl[q][19:16]] = 1'b1;
    end
    `CHK({pc_oe, pb_oe, pa_oe}, oe)
    `CHK({pc_out, pb_out, pa_out} & oe, out & oe)
    `CHK(analog_enable, an)
    `CHK(external_interrupt_input, (route[6:5] == 2'h1) ? pins[11] :
      (route[6:5] == 2'h2) ? pins[8] : pins[7])
    `CHK(capture_timer_input, route[4] ? pins[6] : pins[9])
    `CHK(noise_filter_input, (route[3:2] == 2'h1) ? pins[6] :
      (route[3:2] == 2'h2) ? pins[8] : pins[7])
  endtask : chk_pins

  task automatic summarize();
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  always #12.5 pclk = ~pclk;

  // cut a hang short well past the expected run of under two thousand cycles
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      summarize();
    end
  end

  initial
  begin
    {pclk, presetn, psel, penable, pwrite, power_down} = '0;
    {paddr, pwdata, pa_in, pb_in, pc_in, per, route, wake} = '0;
    for (int k = 0; k < 5; k++) sel[k] = 8'h00;
    for (int k = 0; k < 3; k++) {dat[k], dir[k]} = 16'hFFFF;
    void'($urandom(32'hed17_7286));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, then all-ones into masked and unmapped places
    for (int n = 0; n < 2; n++)
    begin
      for (int x = 0; x <= 'h3C; x += 4) apb(1'b0, 12'(x), 0);
      if (n == 0) apb(1'b1, `PSFS_OFF_ROUTE, '1);
      if (n == 0) apb(1'b1, `PSFS_OFF_PC_HI, '1);
      if (n == 0) apb(1'b1, 12'h03C, '1);
    end
    for (int k = 0; k < 3; k++) apb(1'b1, 12'(36 + 4 * k), 0);
    repeat (4) @(posedge pclk);
    chk_pins();
    for (int n = 0; n < 80; n++)
    begin
      a = 12'(4 * ($urandom % 14));
      d = $urandom;
      d[9:8] = 2'($urandom % 3);
      if (a == `PSFS_OFF_BITOP) d[3] = 1'b1;
      per <= 14'($urandom);
      {pa_in, pb_in, pc_in} <= 18'($urandom);
      apb(1'b1, a, d);
      repeat (4) @(posedge pclk);
      chk_pins();
      apb(1'b0, 12'(4 * ($urandom % 13)), 0);
    end
    // data bit ops on random pads: input bits take the pad, outputs the latch
    for (int n = 0; n < 10; n++)
    begin
      {pa_in, pb_in, pc_in} <= 18'($urandom);
      repeat (4) @(posedge pclk);
      d = {22'h0, 2'($urandom % 3), 8'($urandom) & 8'h87};
      apb(1'b1, `PSFS_OFF_BITOP, d);
      apb(1'b0, 12'(24 + 4 * d[9:8]), 0);
      chk_pins();
    end
    apb(1'b1, `PSFS_OFF_PA_DIR, 32'h0000_00FF);
    for (int n = 0; n < 24; n++)
    begin
      p = $urandom % 8;
      power_down <= 1'($urandom);
      apb(1'b1, 12'(4 + 4 * ($urandom % 2)), $urandom);
      apb(1'b1, `PSFS_OFF_WAKE, $urandom);
      pa_in[p] <= 1'b1;
      repeat (4) @(posedge pclk);
      pa_in[p] <= 1'b0;
      ex = power_down & wake[p] & (kind_of(p) == 4'h0);
      got = 1'b0;
      repeat (6) @(posedge pclk) got = got | wake_request;
      `CHK(got, ex)
    end
    summarize();
  end
endmodule : testbench
